// *** logic/tpic_pkg.sv ***
// package: register map, vectors, levels and bus types for the irq controller
package tpic_pkg;

  localparam int TPIC_NSRC = 7;

  // printed offsets are not multiples of four: kept as indices
  localparam logic [7:0] TPIC_IDX_ENABLE     = 8'ha8;
  localparam logic [7:0] TPIC_IDX_LEVEL_UP   = 8'hb7;
  localparam logic [7:0] TPIC_IDX_LEVEL_LOW  = 8'hb8;
  localparam logic [7:0] TPIC_IDX_PEND       = 8'hc0;
  localparam logic [7:0] TPIC_IDX_MASK       = 8'hc1;
  localparam logic [7:0] TPIC_IDX_ACTIVE     = 8'hc2;

  localparam logic [9:0] TPIC_ADDR_ENABLE    = {TPIC_IDX_ENABLE, 2'b00};
  localparam logic [9:0] TPIC_ADDR_LEVEL_UP  = {TPIC_IDX_LEVEL_UP, 2'b00};
  localparam logic [9:0] TPIC_ADDR_LEVEL_LOW = {TPIC_IDX_LEVEL_LOW, 2'b00};
  localparam logic [9:0] TPIC_ADDR_PEND      = {TPIC_IDX_PEND, 2'b00};
  localparam logic [9:0] TPIC_ADDR_MASK      = {TPIC_IDX_MASK, 2'b00};
  localparam logic [9:0] TPIC_ADDR_ACTIVE    = {TPIC_IDX_ACTIVE, 2'b00};

  localparam int TPIC_GLOBAL_BIT = 7;

  localparam logic [7:0] TPIC_ENABLE_RST    = 8'h00;
  localparam logic [7:0] TPIC_LEVEL_UP_RST  = 8'h00;
  localparam logic [7:0] TPIC_LEVEL_LOW_RST = 8'h00;
  localparam logic [7:0] TPIC_MASK_RST      = 8'h00;

  // source index order equals enable register bit order
  localparam logic [15:0] TPIC_VECTOR_TABLE [TPIC_NSRC] = '{
    16'h0003, 16'h000b, 16'h0013, 16'h001b, 16'h0023, 16'h002b, 16'h0033};

  // polling order, first wins within a level
  localparam logic [2:0] TPIC_POLL_ORDER [TPIC_NSRC] = '{
    3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6};

  // core machine cycle: 12 core clocks
  localparam int TPIC_MCYCLE_CLKS = 12;

  localparam logic [1:0] TPIC_RESP_OKAY   = 2'b00;
  localparam logic [1:0] TPIC_RESP_SLVERR = 2'b10;

  typedef struct packed {
    logic        valid;
    logic [2:0]  source;
    logic [1:0]  level;
    logic [15:0] vector;
  } tpic_request_type;

  typedef enum logic [1:0] {
    TPIC_ST_IDLE,
    TPIC_ST_OFFER
  } tpic_state_type;

endpackage : tpic_pkg

// *** logic/tpic_tick.sv ***
// machine cycle enable divider
`timescale 1ns/1ps
module tpic_tick
  import tpic_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst,
  output logic      tick
);
  logic [3:0] cnt_reg;
  logic [3:0] cnt_next;

  always_comb begin
    if (cnt_reg == 4'(TPIC_MCYCLE_CLKS - 1)) begin
      cnt_next = 4'h0;
    end else begin
      cnt_next = cnt_reg + 4'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_reg <= 4'h0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  assign tick = (cnt_reg == 4'(TPIC_MCYCLE_CLKS - 1));
endmodule : tpic_tick

// *** logic/tpic_arbiter.sv ***
// level and polling-order arbiter over the seven sources
`timescale 1ns/1ps
module tpic_arbiter
  import tpic_pkg::*;
(
  input  wire logic [6:0] req,
  input  wire logic [6:0] lvl_up,
  input  wire logic [6:0] lvl_low,
  output tpic_request_type win
);
  always_comb begin
    logic [1:0] best;
    logic       found;
    logic [1:0] lv;
    best  = 2'b00;
    found = 1'b0;
    lv    = 2'b00;
    win   = '0;
    // scan in polling order; strictly higher level replaces
    for (int i = 0; i < TPIC_NSRC; i++) begin
      lv = {lvl_up[TPIC_POLL_ORDER[i]], lvl_low[TPIC_POLL_ORDER[i]]};
      if (req[TPIC_POLL_ORDER[i]] && (!found || lv > best)) begin
        found      = 1'b1;
        best       = lv;
        win.valid  = 1'b1;
        win.source = TPIC_POLL_ORDER[i];
        win.level  = lv;
        win.vector = TPIC_VECTOR_TABLE[TPIC_POLL_ORDER[i]];
      end
    end
  end
endmodule : tpic_arbiter

// *** logic/tpic_ctrl.sv ***
// interrupt controller top: registers, preemption, vector hand-off
`timescale 1ns/1ps
// Notes on behaviour
// - seven sources, each with own vector
// - each source gated by its enable bit; the IRQ output uses the mask bits instead
// - enable bit 7 clear blocks all vector offers
// - level is upper bit then lower bit
// - counter array vectors to 0033h
// - only strictly higher level preempts
// - level three routine is never preempted
// - higher level wins simultaneous requests
// - polling order breaks ties within level
// - poll order pin0,t0,pin1,t1,uart,t2,array
// - enable register resets zero, bit order
// - upper level register, bit7 reserved zero
module tpic_ctrl
  import tpic_pkg::*;
(
  input  wire logic        CORE_CLK,
  input  wire logic        SYS_RST,
  input  wire logic [6:0]  SRC_REQ,
  output logic             VEC_VALID,
  output logic [15:0]      VEC_ADDR,
  output logic [1:0]       VEC_LEVEL,
  output logic [2:0]       VEC_SOURCE,
  input  wire logic        VEC_TAKEN,
  input  wire logic        RETI_DONE,
  output logic             IRQ,
  input  wire logic [11:0] S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  input  wire logic [11:0] S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY
);

  // 0 means unmapped; upper address bits must be clear
  function automatic logic [2:0] reg_sel(input logic [11:0] a);
    reg_sel = 3'd0;
    if (a[11:10] == 2'b00) begin
      if (a[9:0] == TPIC_ADDR_ENABLE) reg_sel = 3'd1;
      else if (a[9:0] == TPIC_ADDR_LEVEL_UP) reg_sel = 3'd2;
      else if (a[9:0] == TPIC_ADDR_LEVEL_LOW) reg_sel = 3'd3;
      else if (a[9:0] == TPIC_ADDR_PEND) reg_sel = 3'd4;
      else if (a[9:0] == TPIC_ADDR_MASK) reg_sel = 3'd5;
      else if (a[9:0] == TPIC_ADDR_ACTIVE) reg_sel = 3'd6;
    end
  endfunction : reg_sel

  // registers
  logic [7:0]  enable_reg, enable_next;
  logic [6:0]  lvl_up_reg, lvl_up_next;
  logic [6:0]  lvl_low_reg, lvl_low_next;
  logic [6:0]  pend_reg, pend_next;
  logic [6:0]  mask_reg, mask_next;
  logic [3:0]  active_reg, active_next;
  logic [6:0]  req_s1_reg, req_s2_reg;
  tpic_state_type   state_reg, state_next;
  tpic_request_type offer_reg, offer_next;
  logic        aw_got_reg, aw_got_next;
  logic        w_got_reg, w_got_next;
  logic [11:0] awaddr_reg, awaddr_next;
  logic [31:0] wdata_reg, wdata_next;
  logic        wstrb0_reg, wstrb0_next;
  logic        bvalid_reg, bvalid_next;
  logic [1:0]  bresp_reg, bresp_next;
  logic        rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0]  rresp_reg, rresp_next;

  logic             tick;
  tpic_request_type win;
  logic [6:0]       gated;
  logic             preempt_ok;
  logic             wr_fire, rd_fire;
  logic [3:0]       ceiling;

  tpic_tick u_tick (
    .clk  (CORE_CLK),
    .rst  (SYS_RST),
    .tick (tick)
  );

  // requests from other units pass a synchroniser
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      req_s1_reg <= '0;
      req_s2_reg <= '0;
    end else begin
      req_s1_reg <= SRC_REQ;
      req_s2_reg <= req_s1_reg;
    end
  end

  assign gated = enable_reg[TPIC_GLOBAL_BIT] ?
                 (pend_reg & enable_reg[6:0]) : 7'h00;

  tpic_arbiter u_arb (
    .req     (gated),
    .lvl_up  (lvl_up_reg),
    .lvl_low (lvl_low_reg),
    .win     (win)
  );

  // active_reg bit n: a routine of level n is running
  always_comb begin
    ceiling = 4'h0;
    for (int l = 0; l < 4; l++) begin
      if (active_reg[l]) ceiling = 4'(l + 1);
    end
  end
  assign preempt_ok = win.valid && ({2'b00, win.level} >= ceiling);

  assign wr_fire = aw_got_reg && w_got_reg && !bvalid_reg;
  assign rd_fire = S_AXI_ARVALID && S_AXI_ARREADY;

  // vector hand-off and nesting state
  always_comb begin
    state_next  = state_reg;
    offer_next  = offer_reg;
    active_next = active_reg;
    if (RETI_DONE) begin
      for (int l = 3; l >= 0; l--) begin
        if (active_next[l]) begin
          active_next[l] = 1'b0;
          break;
        end
      end
    end
    unique case (state_reg)
      TPIC_ST_IDLE: begin
        if (tick && preempt_ok && !RETI_DONE) begin
          offer_next = win;
          state_next = TPIC_ST_OFFER;
        end
      end
      TPIC_ST_OFFER: begin
        if (VEC_TAKEN) begin
          active_next[offer_reg.level] = 1'b1;
          offer_next.valid = 1'b0;
          state_next = TPIC_ST_IDLE;
        end
      end
    endcase
  end

  // pending flags: source sets, read of pending register clears, set wins
  always_comb begin
    pend_next = pend_reg;
    if (rd_fire && reg_sel(S_AXI_ARADDR) == 3'd4) pend_next = 7'h00;
    if (state_reg == TPIC_ST_OFFER && VEC_TAKEN)
      pend_next[offer_reg.source] = 1'b0;
    pend_next = pend_next | req_s2_reg;
  end

  // axi write side
  always_comb begin
    aw_got_next  = aw_got_reg;
    w_got_next   = w_got_reg;
    awaddr_next  = awaddr_reg;
    wdata_next   = wdata_reg;
    wstrb0_next  = wstrb0_reg;
    bvalid_next  = bvalid_reg;
    bresp_next   = bresp_reg;
    enable_next  = enable_reg;
    lvl_up_next  = lvl_up_reg;
    lvl_low_next = lvl_low_reg;
    mask_next    = mask_reg;
    if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      aw_got_next = 1'b1;
      awaddr_next = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && S_AXI_WREADY) begin
      w_got_next = 1'b1;
      wdata_next = S_AXI_WDATA & {24'h0, {8{S_AXI_WSTRB[0]}}};
      wstrb0_next = S_AXI_WSTRB[0];
    end
    if (wr_fire) begin
      bvalid_next = 1'b1;
      bresp_next  = TPIC_RESP_OKAY;
      unique case (reg_sel(awaddr_reg))
        3'd1: enable_next = wdata_reg[7:0];
        3'd2: lvl_up_next = wdata_reg[6:0];
        3'd3: lvl_low_next = wdata_reg[6:0];
        3'd5: mask_next = wdata_reg[6:0];
        3'd4, 3'd6: ;
        default: bresp_next = TPIC_RESP_SLVERR;
      endcase
      // byte lane 0 off: keep old contents; strobe latched with data
      // because the live strobe may already belong to the next beat
      if (!wstrb0_reg) begin
        enable_next  = enable_reg;
        lvl_up_next  = lvl_up_reg;
        lvl_low_next = lvl_low_reg;
        mask_next    = mask_reg;
      end
    end
    if (bvalid_reg && S_AXI_BREADY) begin
      bvalid_next = 1'b0;
      aw_got_next = 1'b0;
      w_got_next  = 1'b0;
    end
  end

  // axi read side
  always_comb begin
    rvalid_next = rvalid_reg;
    rdata_next  = rdata_reg;
    rresp_next  = rresp_reg;
    if (rd_fire) begin
      rvalid_next = 1'b1;
      rresp_next  = TPIC_RESP_OKAY;
      unique case (reg_sel(S_AXI_ARADDR))
        3'd1: rdata_next = {24'h0, enable_reg};
        3'd2: rdata_next = {25'h0, lvl_up_reg};
        3'd3: rdata_next = {25'h0, lvl_low_reg};
        3'd4: rdata_next = {25'h0, pend_reg};
        3'd5: rdata_next = {25'h0, mask_reg};
        3'd6: rdata_next = {28'h0, active_reg};
        default: begin
          rdata_next = 32'h0;
          rresp_next = TPIC_RESP_SLVERR;
        end
      endcase
    end else if (rvalid_reg && S_AXI_RREADY) begin
      rvalid_next = 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      enable_reg  <= TPIC_ENABLE_RST;
      lvl_up_reg  <= TPIC_LEVEL_UP_RST[6:0];
      lvl_low_reg <= TPIC_LEVEL_LOW_RST[6:0];
      mask_reg    <= TPIC_MASK_RST[6:0];
      pend_reg    <= '0;
      active_reg  <= '0;
      state_reg   <= TPIC_ST_IDLE;
      offer_reg   <= '0;
      aw_got_reg  <= 1'b0;
      w_got_reg   <= 1'b0;
      awaddr_reg  <= '0;
      wdata_reg   <= '0;
      wstrb0_reg  <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= TPIC_RESP_OKAY;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= '0;
      rresp_reg   <= TPIC_RESP_OKAY;
    end else begin
      enable_reg  <= enable_next;
      lvl_up_reg  <= lvl_up_next;
      lvl_low_reg <= lvl_low_next;
      mask_reg    <= mask_next;
      pend_reg    <= pend_next;
      active_reg  <= active_next;
      state_reg   <= state_next;
      offer_reg   <= offer_next;
      aw_got_reg  <= aw_got_next;
      w_got_reg   <= w_got_next;
      awaddr_reg  <= awaddr_next;
      wdata_reg   <= wdata_next;
      wstrb0_reg  <= wstrb0_next;
      bvalid_reg  <= bvalid_next;
      bresp_reg   <= bresp_next;
      rvalid_reg  <= rvalid_next;
      rdata_reg   <= rdata_next;
      rresp_reg   <= rresp_next;
    end
  end

  assign S_AXI_AWREADY = !aw_got_reg;
  assign S_AXI_WREADY  = !w_got_reg;
  assign S_AXI_BVALID  = bvalid_reg;
  assign S_AXI_BRESP   = bresp_reg;
  assign S_AXI_ARREADY = !rvalid_reg;
  assign S_AXI_RVALID  = rvalid_reg;
  assign S_AXI_RDATA   = rdata_reg;
  assign S_AXI_RRESP   = rresp_reg;
  assign VEC_VALID  = offer_reg.valid;
  assign VEC_ADDR   = offer_reg.vector;
  assign VEC_LEVEL  = offer_reg.level;
  assign VEC_SOURCE = offer_reg.source;
  assign IRQ        = |(pend_reg & mask_reg);

  // checks
  property p_global_off;
    @(posedge CORE_CLK) disable iff (SYS_RST)
      (state_reg == TPIC_ST_IDLE && !enable_reg[TPIC_GLOBAL_BIT])
      |=> !VEC_VALID;
  endproperty
  a_global_off: assert property (p_global_off)
    else $error("vector offered with global enable clear");

  property p_source_enabled;
    @(posedge CORE_CLK) disable iff (SYS_RST)
      $rose(VEC_VALID) |->
        (($past(enable_reg) & (8'h01 << VEC_SOURCE)) != 8'h00);
  endproperty
  a_source_enabled: assert property (p_source_enabled)
    else $error("vector offered for disabled source");

  property p_no_preempt_top;
    @(posedge CORE_CLK) disable iff (SYS_RST)
      $rose(VEC_VALID) |-> !$past(active_reg[3]);
  endproperty
  a_no_preempt_top: assert property (p_no_preempt_top)
    else $error("top level routine preempted");

  property p_level_above;
    @(posedge CORE_CLK) disable iff (SYS_RST)
      $rose(VEC_VALID) |-> ({2'b00, VEC_LEVEL} >= $past(ceiling));
  endproperty
  a_level_above: assert property (p_level_above)
    else $error("offer not above running level");

  property p_on_tick;
    @(posedge CORE_CLK) disable iff (SYS_RST)
      $rose(VEC_VALID) |-> $past(tick);
  endproperty
  a_on_tick: assert property (p_on_tick)
    else $error("offer not on machine cycle");

  property p_vector_map;
    @(posedge CORE_CLK) disable iff (SYS_RST)
      VEC_VALID |-> VEC_ADDR == TPIC_VECTOR_TABLE[VEC_SOURCE];
  endproperty
  a_vector_map: assert property (p_vector_map)
    else $error("vector address mismatch");

  property p_array_vec;
    @(posedge CORE_CLK) disable iff (SYS_RST)
      (VEC_VALID && VEC_SOURCE == 3'd6) |-> VEC_ADDR == 16'h0033;
  endproperty
  a_array_vec: assert property (p_array_vec)
    else $error("counter array vector wrong");

  property p_offer_holds;
    @(posedge CORE_CLK) disable iff (SYS_RST)
      (VEC_VALID && !VEC_TAKEN) |=> VEC_VALID && $stable(VEC_ADDR);
  endproperty
  a_offer_holds: assert property (p_offer_holds)
    else $error("offer dropped before taken");

  property p_higher_first;
    @(posedge CORE_CLK) disable iff (SYS_RST)
      $rose(VEC_VALID) |-> $past({lvl_up_reg[0], lvl_low_reg[0]}) <= VEC_LEVEL
        || !$past(gated[0]);
  endproperty
  a_higher_first: assert property (p_higher_first)
    else $error("lower level served first");

  c_offer: cover property (@(posedge CORE_CLK) $rose(VEC_VALID));
  c_nest: cover property (@(posedge CORE_CLK) active_reg == 4'b0011);
  c_top: cover property (@(posedge CORE_CLK) active_reg[3]);
endmodule : tpic_ctrl

// *** sim/tpic_core_model.sv ***
// core model: takes vector offers and ends routines after a delay
`timescale 1ns/1ps
module tpic_core_model
  import tpic_pkg::*;
#(
  parameter int ROUTINE_CLKS = 20
)
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        vec_valid,
  input  wire logic [15:0] vec_addr,
  input  wire logic [1:0]  vec_level,
  input  wire logic [2:0]  vec_source,
  input  wire logic        hold_reti,
  output logic             vec_taken,
  output logic             reti_done,
  output logic [15:0]      got_addr,
  output logic [1:0]       got_level,
  output logic [2:0]       got_source,
  output logic [7:0]       take_count
);
  logic [3:0] depth;
  int         timer;

  // nested routines are counted; each return ends the innermost one
  always_ff @(posedge clk) begin
    if (rst) begin
      vec_taken  <= 1'b0;
      reti_done  <= 1'b0;
      take_count <= 8'h00;
      depth      <= 4'h0;
      timer      <= 0;
      got_addr   <= 16'h0000;
      got_level  <= 2'h0;
      got_source <= 3'h0;
    end else begin
      vec_taken <= 1'b0;
      reti_done <= 1'b0;
      if (vec_valid && !vec_taken) begin
        vec_taken  <= 1'b1;
        got_addr   <= vec_addr;
        got_level  <= vec_level;
        got_source <= vec_source;
        take_count <= take_count + 8'h01;
        depth      <= depth + 4'h1;
        timer      <= 0;
      end else if (depth != 4'h0 && !hold_reti && !reti_done) begin
        if (timer == ROUTINE_CLKS) begin
          reti_done <= 1'b1;
          depth     <= depth - 4'h1;
          timer     <= 0;
        end else begin
          timer <= timer + 1;
        end
      end
    end
  end
endmodule : tpic_core_model

// *** sim/tpic_ctrl_bench.sv ***
// self-checking bench for the irq controller
`timescale 1ns/1ps
module tpic_ctrl_bench;
  import tpic_pkg::*;
  logic        core_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        hold_reti = 1'b0;
  logic [6:0]  src_req = 7'h00;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rdata;
  logic        awready, wready, bvalid, arready, rvalid, irq;
  logic        vec_valid, vec_taken, reti_done;
  logic [1:0]  bresp, rresp, vec_level, got_level;
  logic [15:0] vec_addr, got_addr;
  logic [2:0]  vec_source, got_source;
  logic [7:0]  take_count;
  logic [31:0] d;
  logic [1:0]  r;
  logic [1:0]  bexp = TPIC_RESP_OKAY;
  int          miscompares = 0, checks_done = 0, seen_takes = 0, i;
  logic [15:0] vec_exp [7] = '{16'h0003, 16'h000b, 16'h0013, 16'h001b,
                               16'h0023, 16'h002b, 16'h0033};

  always #12.5 core_clk = ~core_clk;

  tpic_ctrl DUT (.CORE_CLK(core_clk), .SYS_RST(sys_rst), .SRC_REQ(src_req),
    .VEC_VALID(vec_valid), .VEC_ADDR(vec_addr), .VEC_LEVEL(vec_level),
    .VEC_SOURCE(vec_source), .VEC_TAKEN(vec_taken), .RETI_DONE(reti_done),
    .IRQ(irq), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf),
    .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
    .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
    .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));

  tpic_core_model #(.ROUTINE_CLKS(20)) core (.clk(core_clk), .rst(sys_rst),
    .vec_valid(vec_valid), .vec_addr(vec_addr), .vec_level(vec_level),
    .vec_source(vec_source), .hold_reti(hold_reti), .vec_taken(vec_taken),
    .reti_done(reti_done), .got_addr(got_addr), .got_level(got_level),
    .got_source(got_source), .take_count(take_count));

  task automatic check(input string what, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : test_done

  task automatic give_up(input string what);
    check(what, 32'h1, 32'h0);
    test_done();
  endtask : give_up

  task automatic axi_wr(input logic [9:0] a, input logic [7:0] v);
    bit got;
    got = 0;
    @(posedge core_clk);
    awaddr <= {2'b00, a};
    wdata <= {24'h0, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int k = 0; k < 200 && !got; k++) begin
      @(posedge core_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin
        got = 1;
        bready <= 1'b0;
        check("write response", bresp, bexp);
      end
    end
    if (!got) give_up("write timeout");
  endtask : axi_wr

  task automatic axi_rd(input logic [11:0] a);
    bit got;
    got = 0;
    @(posedge core_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int k = 0; k < 200 && !got; k++) begin
      @(posedge core_clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        got = 1;
        d = rdata;
        r = rresp;
        rready <= 1'b0;
      end
    end
    if (!got) give_up("read timeout");
  endtask : axi_rd

  task automatic pulse(input logic [6:0] m);
    @(posedge core_clk);
    src_req <= m;
    @(posedge core_clk);
    src_req <= 7'h00;
  endtask : pulse

  // waits for the next vector taken by the core model
  task automatic take(input int src, input logic [1:0] lvl);
    int k;
    for (k = 0; k < 400 && take_count == seen_takes[7:0]; k++)
      @(posedge core_clk);
    if (k == 400) give_up("vector timeout");
    seen_takes++;
    check("vector source", got_source, src[2:0]);
    check("vector address", got_addr, vec_exp[src]);
    check("vector level", got_level, lvl);
  endtask : take

  task automatic none(input int n);
    repeat (n) @(posedge core_clk);
    check("no vector", take_count, seen_takes[7:0]);
  endtask : none

  initial begin
    repeat (12) @(posedge core_clk);
    sys_rst <= 1'b0;
    axi_rd({2'b00, TPIC_ADDR_ENABLE});
    check("enable reset", d, 32'h0);
    axi_rd({2'b00, TPIC_ADDR_LEVEL_UP});
    check("upper level reset", d, 32'h0);
    axi_rd({2'b00, TPIC_ADDR_MASK});
    check("mask reset", d, 32'h0);
    axi_rd(12'h004);
    check("unmapped response", r, TPIC_RESP_SLVERR);
    axi_wr(TPIC_ADDR_LEVEL_UP, 8'hff);
    axi_rd({2'b00, TPIC_ADDR_LEVEL_UP});
    check("upper level bit7", d, 32'h7f);
    axi_wr(TPIC_ADDR_LEVEL_UP, 8'h00);
    bexp = TPIC_RESP_SLVERR;
    axi_wr(10'h004, 8'h5a);
    bexp = TPIC_RESP_OKAY;
    axi_rd({2'b00, TPIC_ADDR_ENABLE});
    check("enable after stray write", d, 32'h0);
    $display("test registers done");
    axi_wr(TPIC_ADDR_ENABLE, 8'hff);
    pulse(7'h7f);
    for (i = 0; i < 7; i++) take(i, 2'h0);
    $display("test polling order done");
    axi_wr(TPIC_ADDR_LEVEL_UP, 8'h48);
    axi_wr(TPIC_ADDR_LEVEL_LOW, 8'h40);
    pulse(7'h49);
    take(6, 2'h3);
    take(3, 2'h2);
    take(0, 2'h0);
    $display("test levels done");
    axi_wr(TPIC_ADDR_ENABLE, 8'h7f);
    pulse(7'h01);
    none(60);
    axi_wr(TPIC_ADDR_ENABLE, 8'hfe);
    none(60);
    axi_wr(TPIC_ADDR_ENABLE, 8'h81);
    take(0, 2'h0);
    $display("test enables done");
    axi_wr(TPIC_ADDR_ENABLE, 8'hff);
    axi_wr(TPIC_ADDR_LEVEL_UP, 8'h61);
    axi_wr(TPIC_ADDR_LEVEL_LOW, 8'h4b);
    hold_reti <= 1'b1;
    pulse(7'h02);
    take(1, 2'h1);
    pulse(7'h08);
    none(60);
    pulse(7'h20);
    take(5, 2'h2);
    pulse(7'h40);
    take(6, 2'h3);
    pulse(7'h01);
    none(60);
    hold_reti <= 1'b0;
    take(0, 2'h3);
    take(3, 2'h1);
    $display("test preemption done");
    axi_wr(TPIC_ADDR_ENABLE, 8'h00);
    pulse(7'h04);
    repeat (4) @(posedge core_clk);
    check("irq while masked", irq, 1'b0);
    axi_wr(TPIC_ADDR_MASK, 8'h04);
    @(posedge core_clk);
    check("irq unmasked", irq, 1'b1);
    axi_rd({2'b00, TPIC_ADDR_PEND});
    check("pending status", d, 32'h04);
    @(posedge core_clk);
    check("irq after clear", irq, 1'b0);
    $display("test interrupt done");
    test_done();
  end

  initial begin
    repeat (100000) @(posedge core_clk);
    give_up("run timeout");
  end
endmodule : tpic_ctrl_bench
